// ==== src/sar_conv_sequencer.sv ====
// conversion sequencer behind the byte-wide parallel host port
// Overview of operation
// - track/hold goes to tracking when a control byte write ends, except the write that closes external acquisition.
// - external acquisition holds on the next write strobe rising edge.
// - internal acquisition holds on the fourth conversion clock falling edge.
// - single-ended ties negative node to common; differential uses the pair.
// - every conversion lasts exactly 13 conversion clock cycles.
// - a write during conversion aborts it and starts new acquisition.
// - the sample is taken at the end of acquisition, both modes.
// - acquisition bit clear times acquisition internally, then converts.
// - external acquisition opens with bit set, converts on second write.
// - done flag goes low when the result is ready.
// - done flag returns high on first read or new control write.
// - top two bits pick full or standby power-down or normal operation.
// - bit 5 picks internal (0) or external (1) acquisition timing.
// - bit 4 picks pseudo-differential (0) or single-ended (1) inputs.
// - bits 2 to 0 address the input channel or input pair.
// - normal operation uses internal clock for 10, external for 11.
// - power-down keeps last clock mode; power-up uses external clock.
// - read shows low byte, or upper nibble with zero or sign lines.
// - result is straight binary unipolar, two's complement bipolar.
`timescale 1ns/1ps
module sar_conv_sequencer (
   input  wire logic        core_clk_in,         // core clock, 20 MHz
   input  wire logic        reset_in,            // sync reset, active high
   input  wire logic        cs_n_in,             // chip select, active low
   input  wire logic        wr_n_in,             // write strobe, active low
   input  wire logic        rd_n_in,             // read strobe, active low
   input  wire logic        high_byte_enable_in, // read upper nibble
   input  wire logic [7:0]  data_in,             // data pins, input side
   output logic      [7:0]  data_out,            // data pins, output side
   output logic             data_oe_out,         // data pins driven
   input  wire logic        conv_clk_in,         // external conversion clock
   input  wire logic        comp_in,             // comparator decision
   output logic             conv_done_n_out,     // conversion done, low
   output logic             track_out,           // hold capacitor tracking
   output logic             sample_out,          // sampling instant pulse
   output logic [2:0]       pos_chan_out,        // positive input channel
   output logic [2:0]       neg_chan_out,        // negative input channel
   output logic             neg_to_common_out,   // negative node on return
   output logic [1:0]       power_mode_out,      // requested power state
   output logic             clk_mode_ext_out,    // external clock in use
   output logic [11:0]      dac_code_out         // capacitive dac trial code
);

   typedef struct packed {
      // synchronisers, stage 0 feeds stage 1 only
      logic [1:0]                     cs_s;
      logic [1:0]                     wr_s;
      logic [1:0]                     rd_s;
      logic [1:0]                     hb_s;
      logic [2:0]                     clk_s;
      logic [1:0]                     comp_s;
      logic [1:0][7:0]                data_s;
      // host port
      logic                           wr_act_q;
      logic                           rd_act_q;
      logic [7:0]                     wbuf;
      logic [7:0]                     dout;
      logic                           doe;
      // sequencing
      sar_seq_pkg::seq_state_type     state;
      logic [3:0]                     edge_cnt;
      logic [2:0]                     div_cnt;
      logic                           int_tick;
      logic                           sar_start;
      logic                           sar_step;
      // control and results
      logic [7:0]                     ctrl;
      logic                           clk_ext;
      logic [11:0]                    result;
      logic                           done_n;
      logic                           track;
      logic                           sample;
      logic [2:0]                     pos_chan;
      logic [2:0]                     neg_chan;
      logic                           neg_com;
   } seq_type;

   seq_type st;
   seq_type next_st;

   sar_if #(.W(sar_seq_pkg::RESULT_W)) sar ();

   sar_engine #(.W(sar_seq_pkg::RESULT_W)) u_engine (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .sar         (sar.engine)
   );

   assign sar.start = st.sar_start;
   assign sar.step  = st.sar_step;
   assign sar.comp  = st.comp_s[1];

   logic        wr_act;
   logic        rd_act;
   logic        wr_rise;
   logic        rd_fall;
   logic        ext_fall;
   logic        conv_fall;
   logic [7:0]  wbyte;
   logic [11:0] fmt_code;
   logic [2:0]  addr;

   always_comb begin
      next_st  = st;
      wbyte    = st.wbuf;
      addr     = wbyte[sar_seq_pkg::ADDR_MSB:sar_seq_pkg::ADDR_LSB];
      fmt_code = sar.code;

      // pin synchronisers
      next_st.cs_s   = {st.cs_s[0], cs_n_in};
      next_st.wr_s   = {st.wr_s[0], wr_n_in};
      next_st.rd_s   = {st.rd_s[0], rd_n_in};
      next_st.hb_s   = {st.hb_s[0], high_byte_enable_in};
      next_st.clk_s  = {st.clk_s[1:0], conv_clk_in};
      next_st.comp_s = {st.comp_s[0], comp_in};
      next_st.data_s = {st.data_s[0], data_in};

      // chip select gates both strobes
      wr_act   = !st.cs_s[1] && !st.wr_s[1];
      rd_act   = !st.cs_s[1] && !st.rd_s[1];
      wr_rise  = st.wr_act_q && !wr_act;
      rd_fall  = rd_act && !st.rd_act_q;
      next_st.wr_act_q = wr_act;
      next_st.rd_act_q = rd_act;
      if (wr_act) begin
         // keep the last byte seen while the write is low
         next_st.wbuf = st.data_s[1];
      end

      // internal conversion clock from the core clock
      next_st.int_tick = 1'b0;
      if (st.div_cnt == sar_seq_pkg::DIV_LAST) begin
         next_st.div_cnt  = '0;
         next_st.int_tick = 1'b1;
      end else begin
         next_st.div_cnt = st.div_cnt + 3'h1;
      end

      ext_fall  = st.clk_s[2] && !st.clk_s[1];
      conv_fall = st.clk_ext ? ext_fall : st.int_tick;

      next_st.sample    = 1'b0;
      next_st.sar_start = 1'b0;
      next_st.sar_step  = 1'b0;

      // read port: low byte or upper nibble with extension lines
      next_st.doe = rd_act;
      if (st.hb_s[1]) begin
         next_st.dout = {{sar_seq_pkg::EXT_BITS_W{
                            st.result[sar_seq_pkg::RESULT_W-1]
                            && !st.ctrl[sar_seq_pkg::POL_BIT]}},
                         st.result[sar_seq_pkg::RESULT_W-1:
                                   sar_seq_pkg::LOW_BYTE_W]};
      end else begin
         next_st.dout = st.result[sar_seq_pkg::LOW_BYTE_W-1:0];
      end

      // first read cycle clears the done flag
      if (rd_fall) begin
         next_st.done_n = 1'b1;
      end

      case (st.state)
         sar_seq_pkg::ST_IDLE: begin
            next_st.edge_cnt = '0;
         end
         sar_seq_pkg::ST_ACQ_INT: begin
            if (conv_fall) begin
               if (st.edge_cnt == sar_seq_pkg::ACQ_LAST_EDGE) begin
                  // end of timed acquisition: sample and convert
                  next_st.track    = 1'b0;
                  next_st.sample   = 1'b1;
                  next_st.edge_cnt = '0;
                  next_st.state    = sar_seq_pkg::ST_CONVERT;
               end else begin
                  next_st.edge_cnt = st.edge_cnt + 4'h1;
               end
            end
         end
         sar_seq_pkg::ST_ACQ_EXT: begin
            // open-ended tracking until the closing write
            next_st.track = 1'b1;
         end
         sar_seq_pkg::ST_CONVERT: begin
            if (conv_fall) begin
               // edge 0 moves charge to the dac, the rest decide bits
               if (st.edge_cnt == '0) begin
                  next_st.sar_start = 1'b1;
               end else begin
                  next_st.sar_step = 1'b1;
               end
               if (st.edge_cnt == sar_seq_pkg::CONV_LAST_EDGE) begin
                  next_st.state = sar_seq_pkg::ST_LATCH;
               end else begin
                  next_st.edge_cnt = st.edge_cnt + 4'h1;
               end
            end
         end
         sar_seq_pkg::ST_LATCH: begin
            // wait one cycle so the last decision reaches the code
            if (!st.sar_step) begin
               if (!st.ctrl[sar_seq_pkg::POL_BIT]) begin
                  // offset binary to two's complement for bipolar
                  fmt_code[sar_seq_pkg::RESULT_W-1] =
                     !sar.code[sar_seq_pkg::RESULT_W-1];
               end
               next_st.result = fmt_code;
               next_st.done_n = 1'b0;
               next_st.state  = sar_seq_pkg::ST_IDLE;
            end
         end
         default: begin
            next_st.state = sar_seq_pkg::ST_IDLE;
         end
      endcase

      // a completed control write overrides whatever was under way
      if (wr_rise) begin
         next_st.ctrl   = wbyte;
         next_st.done_n = 1'b1;
         if (wbyte[sar_seq_pkg::PD_HI_BIT]) begin
            next_st.clk_ext = wbyte[sar_seq_pkg::PD_LO_BIT];
         end
         // power-down patterns leave the clock mode alone
         next_st.pos_chan = addr;
         if (wbyte[sar_seq_pkg::CFG_BIT]) begin
            next_st.neg_com  = 1'b1;
            next_st.neg_chan = addr;
         end else begin
            next_st.neg_com  = 1'b0;
            next_st.neg_chan = addr ^ sar_seq_pkg::PAIR_FLIP;
         end
         next_st.edge_cnt = '0;
         if ((st.state == sar_seq_pkg::ST_ACQ_EXT)
             && !wbyte[sar_seq_pkg::ACQ_BIT]) begin
            // closing write of external acquisition
            next_st.track  = 1'b0;
            next_st.sample = 1'b1;
            next_st.state  = sar_seq_pkg::ST_CONVERT;
         end else begin
            // restarts acquisition, aborting any conversion
            next_st.track = 1'b1;
            if (wbyte[sar_seq_pkg::ACQ_BIT]) begin
               next_st.state = sar_seq_pkg::ST_ACQ_EXT;
            end else begin
               next_st.state = sar_seq_pkg::ST_ACQ_INT;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         st         <= '0;
         st.cs_s    <= 2'h3;
         st.wr_s    <= 2'h3;
         st.rd_s    <= 2'h3;
         st.state   <= sar_seq_pkg::ST_IDLE;
         st.ctrl    <= sar_seq_pkg::CTRL_RESET;
         st.clk_ext <= 1'b1;
         st.done_n  <= 1'b1;
         st.neg_com <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // every output is a register field
   assign data_out          = st.dout;
   assign data_oe_out       = st.doe;
   assign conv_done_n_out   = st.done_n;
   assign track_out         = st.track;
   assign sample_out        = st.sample;
   assign pos_chan_out      = st.pos_chan;
   assign neg_chan_out      = st.neg_chan;
   assign neg_to_common_out = st.neg_com;
   assign power_mode_out    = st.ctrl[sar_seq_pkg::PD_HI_BIT:
                                      sar_seq_pkg::PD_LO_BIT];
   assign clk_mode_ext_out  = st.clk_ext;
   assign dac_code_out      = sar.code;

endmodule

// ==== src/sar_seq_pkg.sv ====
// shared constants and types for the converter sequencer
package sar_seq_pkg;

   // control byte layout
   localparam int CTRL_W       = 8;
   localparam int PD_HI_BIT    = 7;
   localparam int PD_LO_BIT    = 6;
   localparam int ACQ_BIT      = 5;
   localparam int CFG_BIT      = 4;
   localparam int POL_BIT      = 3;
   localparam int ADDR_MSB     = 2;
   localparam int ADDR_LSB     = 0;
   localparam int ADDR_W       = 3;

   // power-up: normal operation, external conversion clock
   localparam logic [7:0] CTRL_RESET = 8'hc0;
   localparam logic [2:0] PAIR_FLIP  = 3'h1;

   // result and read port layout
   localparam int RESULT_W     = 12;
   localparam int LOW_BYTE_W   = 8;
   localparam int HIGH_NIB_W   = 4;
   localparam int EXT_BITS_W   = 4;

   // timing
   localparam int CLK_PERIOD_NS    = 50;
   localparam int INT_CONV_TIME_NS = 3600;
   localparam int CONV_CYCLES      = 13;
   localparam int ACQ_INT_EDGES    = 4;
   localparam int INT_DIV_CYCLES   =
      INT_CONV_TIME_NS / (CONV_CYCLES * CLK_PERIOD_NS);

   localparam logic [3:0] CONV_LAST_EDGE = 4'(CONV_CYCLES - 1);
   localparam logic [3:0] ACQ_LAST_EDGE  = 4'(ACQ_INT_EDGES - 1);
   localparam logic [2:0] DIV_LAST       = 3'(INT_DIV_CYCLES - 1);

   typedef enum logic [4:0] {
      ST_IDLE    = 5'h01,
      ST_ACQ_INT = 5'h02,
      ST_ACQ_EXT = 5'h04,
      ST_CONVERT = 5'h08,
      ST_LATCH   = 5'h10
   } seq_state_type;

endpackage

// ==== src/sar_if.sv ====
// successive-approximation engine link between sequencer and engine
`timescale 1ns/1ps
interface sar_if #(parameter int W = 12);
   logic         start;
   logic         step;
   logic         comp;
   logic [W-1:0] code;

   modport engine (input start, input step, input comp, output code);
   modport ctrl   (output start, output step, output comp, input code);
endinterface

// ==== src/sar_engine.sv ====
// successive-approximation register that drives the capacitive dac code
`timescale 1ns/1ps
module sar_engine #(
   parameter int W = 12
) (
   input  wire logic core_clk_in, // core clock
   input  wire logic reset_in,    // synchronous reset, active high
   sar_if.engine     sar          // start, step, comparator, code
);

   typedef struct packed {
      logic [W-1:0] code;
      logic [W-1:0] mask;
   } sar_state_type;

   sar_state_type st;
   sar_state_type next_st;

   always_comb begin
      next_st = st;
      if (sar.start) begin
         // first trial at mid scale
         next_st.code = {1'b1, {(W-1){1'b0}}};
         next_st.mask = {1'b1, {(W-1){1'b0}}};
      end else if (sar.step && (st.mask != '0)) begin
         // comparator high keeps the trial bit
         next_st.code = (sar.comp ? st.code : (st.code & ~st.mask))
                        | (st.mask >> 1);
         next_st.mask = st.mask >> 1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sar.code = st.code;

endmodule

// ==== bench/sar_seq_monitor.sv ====
// port checker for the conversion sequencer
`timescale 1ns/1ps
module sar_seq_monitor (
   input wire logic       core_clk_in,         // core clock
   input wire logic       reset_in,            // sync reset
   input wire logic       cs_n_in,             // chip select
   input wire logic       wr_n_in,             // write strobe
   input wire logic       rd_n_in,             // read strobe
   input wire logic       high_byte_enable_in, // upper nibble
   input wire logic [7:0] data_in,             // control byte
   input wire logic [7:0] data_out,            // read data
   input wire logic       data_oe_out,         // read drive
   input wire logic       conv_clk_in,         // conversion clock
   input wire logic       conv_done_n_out,     // done flag
   input wire logic       track_out,           // tracking
   input wire logic       sample_out,          // sample pulse
   input wire logic [2:0] pos_chan_out,        // positive channel
   input wire logic [2:0] neg_chan_out,        // negative channel
   input wire logic       neg_to_common_out,   // node on return
   input wire logic [1:0] power_mode_out,      // power state
   input wire logic       clk_mode_ext_out     // clock source
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   logic       wr_q;
   logic       cc_q;
   logic       last_acq;
   logic       last_pol;
   logic       close_ext;
   logic       wr_end;
   logic [4:0] falls;
   assign wr_end = wr_n_in & ~wr_q & ~cs_n_in;
   // raw clock falls since the last write or sample, saturating
   always_ff @(posedge core_clk_in) begin
      wr_q <= wr_n_in;
      cc_q <= conv_clk_in;
      if (reset_in) begin
         last_acq <= 1'b0;
         last_pol <= 1'b0;
         close_ext <= 1'b0;
      end else if (wr_end) begin
         last_acq <= data_in[sar_seq_pkg::ACQ_BIT];
         last_pol <= data_in[sar_seq_pkg::POL_BIT];
         close_ext <= last_acq & ~data_in[sar_seq_pkg::ACQ_BIT];
      end
      if (reset_in || wr_end || sample_out) begin
         falls <= 5'h00;
      end else if (cc_q && !conv_clk_in && falls != 5'h1f) begin
         falls <= falls + 5'h01;
      end
   end
   property p_track_open;
      wr_end && data_in[5] |-> ##[2:5] track_out ##1 track_out[*8];
   endproperty
   a_track_open: assert property (p_track_open)
      else $error("tracking not opened by write");
   property p_ext_close;
      wr_end && last_acq && !data_in[5] |-> ##[2:6] sample_out;
   endproperty
   a_ext_close: assert property (p_ext_close)
      else $error("closing write did not sample");
   property p_int_hold;
      sample_out && !last_acq && !close_ext && clk_mode_ext_out
         |-> falls inside {[4:5]};
   endproperty
   a_int_hold: assert property (p_int_hold)
      else $error("hold not on fourth clock fall");
   property p_sample;
      sample_out |-> !track_out ##1 !sample_out;
   endproperty
   a_sample: assert property (p_sample)
      else $error("sample pulse wrong");
   property p_conv_len;
      $fell(conv_done_n_out) && clk_mode_ext_out |-> falls inside {[12:14]};
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion length wrong");
   property p_wr_clear;
      wr_end |-> ##[2:5] conv_done_n_out;
   endproperty
   a_wr_clear: assert property (p_wr_clear)
      else $error("write did not clear done");
   property p_rd_clear;
      !cs_n_in && !rd_n_in && !conv_done_n_out ##1
         (!cs_n_in && !rd_n_in)[*3] |=> conv_done_n_out;
   endproperty
   a_rd_clear: assert property (p_rd_clear)
      else $error("read did not clear done");
   property p_neg_node;
      neg_chan_out ==
         (neg_to_common_out ? pos_chan_out : pos_chan_out ^ 3'h1);
   endproperty
   a_neg_node: assert property (p_neg_node)
      else $error("negative node wrong");
   property p_clk_mode;
      $changed(clk_mode_ext_out)
         |-> power_mode_out == {1'b1, clk_mode_ext_out};
   endproperty
   a_clk_mode: assert property (p_clk_mode)
      else $error("clock mode changed wrongly");
   property p_upper;
      high_byte_enable_in[*4] ##0 data_oe_out
         |-> data_out[7:4] == (last_pol ? 4'h0 : {4{data_out[3]}});
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper lines wrong");
endmodule
bind sar_conv_sequencer sar_seq_monitor u_mon (
   .core_clk_in(core_clk_in), .reset_in(reset_in), .cs_n_in(cs_n_in),
   .wr_n_in(wr_n_in), .rd_n_in(rd_n_in),
   .high_byte_enable_in(high_byte_enable_in), .data_in(data_in),
   .data_out(data_out), .data_oe_out(data_oe_out),
   .conv_clk_in(conv_clk_in), .conv_done_n_out(conv_done_n_out),
   .track_out(track_out), .sample_out(sample_out),
   .pos_chan_out(pos_chan_out), .neg_chan_out(neg_chan_out),
   .neg_to_common_out(neg_to_common_out),
   .power_mode_out(power_mode_out), .clk_mode_ext_out(clk_mode_ext_out));

// ==== bench/host_model.sv ====
// host processor model for the byte-wide control port
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk_in,   // core clock
   input  wire logic [7:0] rdata_in, // device read data
   input  wire logic       oe_in,    // device drives data
   output logic            cs_n_out, // chip select
   output logic            wr_n_out, // write strobe
   output logic            rd_n_out, // read strobe
   output logic            high_byte_enable_out, // upper nibble select
   output logic [7:0]      data_out  // control byte
);
   initial begin
      cs_n_out = 1'b1;
      wr_n_out = 1'b1;
      rd_n_out = 1'b1;
      high_byte_enable_out = 1'b0;
      data_out = 8'h00;
   end
   task automatic write_byte(input logic [7:0] b);
      @(negedge clk_in);
      cs_n_out = 1'b0;
      wr_n_out = 1'b0;
      data_out = b;
      repeat (4) @(negedge clk_in);
      wr_n_out = 1'b1;
      repeat (3) @(negedge clk_in);
      cs_n_out = 1'b1;
      // released bus must not keep the old byte
      data_out = ~b;
      repeat (3) @(negedge clk_in);
   endtask
   task automatic read_byte(input logic hb, output logic [7:0] d);
      int n;
      @(negedge clk_in);
      high_byte_enable_out = hb;
      cs_n_out = 1'b0;
      rd_n_out = 1'b0;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (!oe_in && n < 20);
      d = oe_in ? rdata_in : 8'hxx;
      @(negedge clk_in);
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
      repeat (4) @(negedge clk_in);
   endtask
endmodule

// ==== bench/sar_conv_sequencer_tb_top.sv ====
// testbench for the conversion sequencer
`timescale 1ns/1ps
module sar_conv_sequencer_tb_top;
   logic        clk, rst, cs_n, wr_n, rd_n, high_byte_enable, conv_clk, comp;
   logic        oe, done_n, track, sample, ntc, clk_ext;
   logic [7:0]  din, dout, b;
   logic [2:0]  pch, nch;
   logic [1:0]  pmode;
   logic [11:0] code, ain;
   int          fail_count, checks;
   sar_conv_sequencer DUT (.core_clk_in(clk), .reset_in(rst),
      .cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n),
      .high_byte_enable_in(high_byte_enable), .data_in(din), .data_out(dout),
      .data_oe_out(oe), .conv_clk_in(conv_clk), .comp_in(comp),
      .conv_done_n_out(done_n), .track_out(track), .sample_out(sample),
      .pos_chan_out(pch), .neg_chan_out(nch), .neg_to_common_out(ntc),
      .power_mode_out(pmode), .clk_mode_ext_out(clk_ext),
      .dac_code_out(code));
   host_model host (.clk_in(clk), .rdata_in(dout), .oe_in(oe),
      .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n),
      .high_byte_enable_out(high_byte_enable), .data_out(din));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // external conversion clock, 8 core cycles, edges on falling core edges
   initial begin
      conv_clk = 1'b1;
      forever #200 conv_clk = ~conv_clk;
   end
   // ideal comparator on the analog input
   always @(negedge clk) comp <= (ain >= code);
   task automatic check(input string what, input logic [11:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [15:0] expect_read(input logic [11:0] a,
                                               input logic uni);
      logic [11:0] r;
      r = uni ? a : a ^ 12'h800;
      return {uni ? 4'h0 : {4{r[11]}}, r};
   endfunction
   task automatic wait_done;
      int n;
      n = 0;
      while (done_n !== 1'b0 && n < 400) begin
         @(negedge clk);
         n++;
      end
      check("done", done_n, 1'b0);
   endtask
   task automatic convert(input logic [7:0] b, input logic [11:0] a,
                          input logic ext);
      logic [15:0] e;
      logic [7:0]  lo;
      logic [7:0]  hi;
      e = expect_read(a, b[3]);
      ain = a;
      if (ext) begin
         host.write_byte(b | 8'h20);
         repeat (60) @(negedge clk);
         check("ext_track", track, 1'b1);
         check("ext_done", done_n, 1'b1);
      end
      host.write_byte(b);
      check("track", track, !ext);
      check("pos_chan", pch, b[2:0]);
      check("common", ntc, b[4]);
      check("neg_chan", nch, b[4] ? b[2:0] : b[2:0] ^ 3'h1);
      check("power", pmode, b[7:6]);
      if (b[7]) check("clk_ext", clk_ext, b[6]);
      wait_done;
      host.read_byte(1'b0, lo);
      check("done_clear", done_n, 1'b1);
      host.read_byte(1'b1, hi);
      check("low", lo, e[7:0]);
      check("high", hi, e[15:8]);
      host.read_byte(1'b0, lo);
      check("hold", lo, e[7:0]);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      fail_count++;
      conclude;
   end
   initial begin
      rst = 1'b1;
      ain = 12'h000;
      fail_count = 0;
      checks = 0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      void'($urandom(29400));
      check("rst_power", pmode, 2'h3);
      check("rst_clk", clk_ext, 1'b1);
      check("rst_done", done_n, 1'b1);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         b = {i < 3 ? 2'h3 : 2'h2, 1'b0, 5'($urandom)};
         ain = 12'($urandom);
         if (i == 0) ain = 12'hfff;
         if (i == 1) ain = 12'h000;
         convert(b, ain, 1'b0);
      end
      $display("test conversions done");
      for (int k = 0; k < 2; k++) begin
         b = k[0] ? 8'h5a : 8'h13;
         host.write_byte(b);
         check("pd_power", pmode, b[7:6]);
         check("pd_clk", clk_ext, 1'b0);
      end
      $display("test power done");
      for (int k = 0; k < 2; k++) begin
         convert({2'h3, 1'b0, 5'($urandom)}, 12'($urandom), 1'b1);
      end
      $display("test ext acq done");
      host.write_byte(8'hd5);
      wait_done;
      host.write_byte(8'hd5);
      check("wr_clear", done_n, 1'b1);
      repeat (40) @(negedge clk);
      check("mid_done", done_n, 1'b1);
      // held sample proves the rewrite below lands mid-conversion
      check("mid_track", track, 1'b0);
      convert(8'hd9, 12'($urandom), 1'b0);
      $display("test abort done");
      conclude;
   end
endmodule
